// ### design/hia_pkg.sv
// Package: register map, reset values and carriers of the interrupt hub
package hia_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  HIA_IDX_CTL   = 8'h23;
  localparam logic [7:0]  HIA_IDX_STS   = 8'h24;
  localparam logic [7:0]  HIA_IDX_EVT   = 8'h30;
  localparam logic [7:0]  HIA_IDX_MSK   = 8'h31;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          HIA_BIT_GEN   = 7;
  localparam int          HIA_BIT_SUM   = 7;
  localparam int          HIA_BIT_TX    = 4;
  localparam int          HIA_NSRC      = 5;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and write masks
  localparam logic [7:0]  HIA_CTL_RST   = 8'h00;
  localparam logic [7:0]  HIA_CTL_WMSK  = 8'hbf; // Bit 6 is not writable
  localparam logic [4:0]  HIA_PEND_RST  = 5'h00;
  localparam logic [4:0]  HIA_EVT_RST   = 5'h00;
  localparam logic [4:0]  HIA_MSK_RST   = 5'h00;
  localparam logic [31:0] HIA_RD_RST    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam logic [1:0]  HIA_HRESP_OK  = 2'h0;

  // One bit per source: transmit port above the four receive ports
  typedef struct packed {
    logic       tx;
    logic [3:0] rx;
  } hia_src_t;

  // Captured write address phase
  typedef struct packed {
    logic ctl;
    logic sts;
    logic evt;
    logic msk;
  } hia_wsel_t;

endpackage

// ### design/hia_top.sv
// Interrupt aggregation hub with an AHB-Lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Host line asserts only while global enable and summary are set.
// [RULE2] Control bit 4 enables the transmit-port source into the summary.
// [RULE3] Control bits 3..0 enable receive ports 3..0 into the summary.
// [RULE4] Status bit 7 reads one when any pending source is also enabled.
// [RULE5] Summary ignores global enable; the enable only gates the line.
// [RULE6] Transmit pending sets on its event, clears on its status read.
// [RULE7] Receive pending bits 3..0 set on an event of that port.
// [RULE8] Receive pending clears only after the host reads its causes.
// [RULE9] Status is read only; all control enables reset to zero.
// [RULE10] Pending holds until its clearing read; summary is live.
module hia_top (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [1:0]                hresp,
  output logic [31:0]               hrdata,
  // Source sub-blocks, same clock
  input  wire hia_pkg::hia_src_t    src_event,
  input  wire logic                 tx_status_read,
  input  wire logic [3:0]           rx_causes_read,
  // Interrupt outputs
  output logic                      host_int,
  output logic                      sys_irq
);
  import hia_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [4:0]  pend_r;
  logic [4:0]  pend_nxt;
  logic [4:0]  evt_r;
  logic [4:0]  evt_nxt;
  logic [4:0]  msk_r;
  logic [4:0]  msk_nxt;
  hia_wsel_t   wsel_r;
  hia_wsel_t   wsel_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        host_int_r;
  logic        host_int_nxt;
  logic        sys_irq_r;
  logic        sys_irq_nxt;
  logic        hreadyout_r;
  logic [1:0]  hresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [7:0]  idx);
    reg_hit = (a == {22'h000000, idx, 2'b00});
  endfunction

  // Only whole-word single transfers are expected; hsize is not checked
  wire         a_valid = hsel & htrans[1] & hready;
  wire         a_rd    = a_valid & ~hwrite;
  wire         a_wr    = a_valid & hwrite;
  wire         hit_ctl = reg_hit(haddr, HIA_IDX_CTL);
  wire         hit_sts = reg_hit(haddr, HIA_IDX_STS);
  wire         hit_evt = reg_hit(haddr, HIA_IDX_EVT);
  wire         hit_msk = reg_hit(haddr, HIA_IDX_MSK);
  wire         unused_hsize = |hsize;

  ////////////////////////////////////////////////////////////////////////
  // Source view and summary
  wire [4:0]   src_vec  = src_event;
  wire [4:0]   clr_vec  = {tx_status_read, rx_causes_read};
  wire [4:0]   src_en   = ctl_r[HIA_BIT_TX:0];     // RULE2 RULE3
  wire         summary  = |(pend_r & src_en);      // RULE4 RULE5 RULE10
  wire [3:0]   keep_rx  = pend_r[3:0] & ~rx_causes_read;
  wire [3:0]   clr_rx   = rx_causes_read & ~src_event.rx;
  wire [7:0]   sts_view = {summary, 2'b00, pend_r};

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read as zero
  wire [31:0]  rd_mux =
    hit_ctl ? {24'h000000, ctl_r} :
    hit_sts ? {24'h000000, sts_view} :
    hit_evt ? {27'h0000000, evt_r} :
    hit_msk ? {27'h0000000, msk_r} : HIA_RD_RST;

  ////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    wsel_nxt.ctl = a_wr & hit_ctl;
    wsel_nxt.sts = a_wr & hit_sts;                 // RULE9
    wsel_nxt.evt = a_wr & hit_evt;
    wsel_nxt.msk = a_wr & hit_msk;
    hrdata_nxt   = a_rd ? rd_mux : HIA_RD_RST;
  end

  // Data-phase writes; status writes fall through with no effect
  always_comb begin
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    if (wsel_r.ctl) begin
      ctl_nxt = hwdata[7:0] & HIA_CTL_WMSK;
    end
    if (wsel_r.msk) begin
      msk_nxt = hwdata[4:0];
    end
  end

  // Pending flags: a set in the clearing cycle wins
  always_comb begin
    pend_nxt = src_vec | (pend_r & ~clr_vec);    // RULE6 RULE7 RULE8 RULE10
  end

  // Sticky event bits, write one to clear, new event wins
  always_comb begin
    evt_nxt = src_vec | (evt_r & ~(wsel_r.evt ? hwdata[4:0] : 5'h00));
  end

  // Outputs track the register values they are built from
  always_comb begin
    host_int_nxt = ctl_nxt[HIA_BIT_GEN] &
                   (|(pend_nxt & ctl_nxt[HIA_BIT_TX:0])); // RULE1
    sys_irq_nxt  = |(evt_nxt & msk_nxt);
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= HIA_CTL_RST;                      // RULE9
      msk_r <= HIA_MSK_RST;
    end else begin
      ctl_r <= ctl_nxt;
      msk_r <= msk_nxt;
    end
  end

  // Pending and event flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= HIA_PEND_RST;
      evt_r  <= HIA_EVT_RST;
    end else begin
      pend_r <= pend_nxt;
      evt_r  <= evt_nxt;
    end
  end

  // Bus phase registers; zero wait states, so ready stays high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsel_r      <= '0;
      hrdata_r    <= HIA_RD_RST;
      hreadyout_r <= 1'b1;
      hresp_r     <= HIA_HRESP_OK;
    end else begin
      wsel_r      <= wsel_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= HIA_HRESP_OK;
    end
  end

  // Interrupt lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_int_r <= 1'b0;
      sys_irq_r  <= 1'b0;
    end else begin
      host_int_r <= host_int_nxt;
      sys_irq_r  <= sys_irq_nxt;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign hrdata    = hrdata_r;
  assign host_int  = host_int_r;
  assign sys_irq   = sys_irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  int_gate_a: assert property ( // RULE1
    @(posedge hclk) disable iff (!hresetn)
    host_int == (ctl_r[HIA_BIT_GEN] && summary))
    else $error("host interrupt does not match enable and summary");

  tx_gate_a: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_r[HIA_BIT_TX] && pend_r[3:0] == 4'h0) |-> !summary)
    else $error("disabled transmit source reached summary");

  rx_gate_a: assert property ( // RULE3
    @(posedge hclk) disable iff (!hresetn)
    (!pend_r[HIA_BIT_TX] && (pend_r[3:0] & ctl_r[3:0]) == 4'h0)
      |-> !summary)
    else $error("disabled receive source reached summary");

  sum_read_a: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    (a_rd && hit_sts && |(pend_r & ctl_r[HIA_BIT_TX:0]))
      |=> hrdata[HIA_BIT_SUM])
    else $error("summary bit not read as one");

  sum_indep_a: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_r[HIA_BIT_GEN] && a_rd && hit_sts && summary)
      |=> (hrdata[HIA_BIT_SUM] && !$past(host_int)))
    else $error("global enable changed the summary bit");

  tx_pend_a: assert property ( // RULE6
    @(posedge hclk) disable iff (!hresetn)
    (pend_r[HIA_BIT_TX] && tx_status_read && !src_event.tx)
      |=> !pend_r[HIA_BIT_TX])
    else $error("transmit pending not cleared by its read");

  rx_set_a: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    (src_event.rx != 4'h0)
      |=> ((pend_r[3:0] & $past(src_event.rx)) == $past(src_event.rx)))
    else $error("receive event did not set its pending bit");

  rx_hold_a: assert property ( // RULE8
    @(posedge hclk) disable iff (!hresetn)
    (keep_rx != 4'h0)
      |=> ((pend_r[3:0] & $past(keep_rx)) == $past(keep_rx)))
    else $error("receive pending cleared without its read");

  sts_ro_a: assert property ( // RULE9
    @(posedge hclk) disable iff (!hresetn)
    (wsel_r.sts && src_vec == 5'h00 && clr_vec == 5'h00)
      |=> ($stable(pend_r) && $stable(ctl_r)))
    else $error("status write changed state");

  tx_hold_a: assert property ( // RULE10
    @(posedge hclk) disable iff (!hresetn)
    $fell(pend_r[HIA_BIT_TX]) |-> $past(tx_status_read))
    else $error("transmit pending dropped without a read");

  // Enable low keeps the line quiet whatever is pending
  line_off_a: assert property ( // RULE1
    @(posedge hclk) disable iff (!hresetn)
    !ctl_r[HIA_BIT_GEN] |-> !host_int)
    else $error("host interrupt raised with global enable low");

  // Status reads with no enabled source show a clear summary
  sum_off_a: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    (a_rd && hit_sts && (pend_r & ctl_r[HIA_BIT_TX:0]) == 5'h00)
      |=> !hrdata[HIA_BIT_SUM])
    else $error("summary bit read as one with nothing enabled");

  // A transmit flag with its enable low stays out of the summary
  tx_mask_a: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    (a_rd && hit_sts && !ctl_r[HIA_BIT_TX]
      && (pend_r[3:0] & ctl_r[3:0]) == 4'h0) |=> !hrdata[HIA_BIT_SUM])
    else $error("disabled transmit source read in summary");

  // Toggling the global enable alone never moves the summary
  sum_free_a: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    ($changed(ctl_r[HIA_BIT_GEN]) && $stable(pend_r)
      && $stable(ctl_r[HIA_BIT_TX:0])) |-> $stable(summary))
    else $error("global enable moved the summary");

  // Transmit event sets its flag on the next edge
  tx_set_a: assert property ( // RULE6
    @(posedge hclk) disable iff (!hresetn)
    src_event.tx |=> pend_r[HIA_BIT_TX])
    else $error("transmit event did not set its pending bit");

  // No receive flag appears after a cycle with no event on any receive port
  rx_quiet_a: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    (src_event.rx == 4'h0)
      |=> (((pend_r & ~$past(pend_r)) & 5'h0f) == 5'h00))
    else $error("receive pending set without an event");

  // A cause read with no event that cycle drops the port's flag
  rx_clear_a: assert property ( // RULE8
    @(posedge hclk) disable iff (!hresetn)
    (clr_rx != 4'h0) |=> ((pend_r[3:0] & $past(clr_rx)) == 4'h0))
    else $error("receive pending not cleared by its read");

  // Without any clear every set flag stays set; checked on the whole
  // vector so a stray clear of one source cannot hide behind another
  pend_keep_a: assert property ( // RULE10
    @(posedge hclk) disable iff (!hresetn)
    (clr_vec == 5'h00) |=> ((pend_r & $past(pend_r)) == $past(pend_r)))
    else $error("pending bit dropped with no clear");

  // Status reads carry zeros in every unused bit
  sts_bits_a: assert property ( // RULE9
    @(posedge hclk) disable iff (!hresetn)
    (a_rd && hit_sts)
      |=> (hrdata[6:5] == 2'b00 && hrdata[31:8] == 24'h000000))
    else $error("status read shows a reserved bit set");

endmodule

// ### test/hia_host_model.sv
// Host controller model: counts interrupt requests from the hub
`timescale 1ns/1ps
module hia_host_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Interrupt line from the hub
  input  wire logic        host_int,
  output logic [15:0]      int_count
);
  logic line_r;
  // Edge count; a held level is one request, not many
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_r    <= 1'b0;
      int_count <= 16'h0;
    end else begin
      line_r <= host_int;
      if (host_int && !line_r) begin
        int_count <= int_count + 16'h1;
      end
    end
  end
endmodule

// ### test/hia_top_test.sv
// Self-checking bench of the interrupt hub over AHB-Lite
`timescale 1ns/1ps
module hia_top_test;
  import hia_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [31:0] hrdata;
  hia_src_t    src_event = '0;
  logic        tx_status_read = 1'b0;
  logic [3:0]  rx_causes_read = 4'h0;
  logic        host_int;
  logic        sys_irq;
  logic [15:0] int_count;
  logic [31:0] rd;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  //////////////////////////////////////////////////////////////////////////
  // Design and host model; single slave, so hready is its own hreadyout
  hia_top hia_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_event(src_event),
    .tx_status_read(tx_status_read), .rx_causes_read(rx_causes_read),
    .host_int(host_int), .sys_irq(sys_irq));
  hia_host_model hia_host_model_inst (.hclk(hclk), .hresetn(hresetn),
    .host_int(host_int), .int_count(int_count));
  // Clock and hang guard
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // One-cycle pulses on the source side, then time to settle
  task automatic pulse(input logic [4:0] ev, input logic tr,
                       input logic [3:0] rr);
    @(posedge hclk);
    src_event      <= hia_src_t'(ev);
    tx_status_read <= tr;
    rx_causes_read <= rr;
    @(posedge hclk);
    src_event      <= '0;
    tx_status_read <= 1'b0;
    rx_causes_read <= 4'h0;
    repeat (2) @(posedge hclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(1'b0, HIA_IDX_CTL, 0);
    chk(rd, 32'h0);
    bus(1'b1, HIA_IDX_STS, 32'hff);
    bus(1'b0, HIA_IDX_STS, 0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h3f, 0);
    chk(rd, 32'h0);
    bus(1'b1, HIA_IDX_CTL, 32'hff);
    bus(1'b0, HIA_IDX_CTL, 0);
    chk(rd, 32'hbf);
    chk({30'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
  endtask
  // Sticky event bits, mask, write-one-to-clear
  task automatic t_irq;
    bus(1'b1, HIA_IDX_CTL, 0);
    bus(1'b1, HIA_IDX_MSK, 32'h04);
    bus(1'b0, HIA_IDX_MSK, 0);
    chk(rd, 32'h04);
    pulse(5'h05, 1'b0, 4'h0);
    chk({31'h0, sys_irq}, 32'h1);
    chk({31'h0, host_int}, 32'h0);
    bus(1'b1, HIA_IDX_EVT, 32'h04);
    bus(1'b0, HIA_IDX_EVT, 0);
    chk(rd, 32'h01);
    chk({31'h0, sys_irq}, 32'h0);
    bus(1'b1, HIA_IDX_EVT, 32'h01);
    pulse(5'h00, 1'b0, 4'h5);
    bus(1'b0, HIA_IDX_STS, 0);
    chk(rd, 32'h0);
  endtask
  // Each source in turn: enables, summary, line, clearing reads
  task automatic t_sources;
    logic [4:0] b;
    for (int i = 0; i < HIA_NSRC; i++) begin
      b = 5'h01 << i;
      pulse(b, 1'b0, 4'h0);
      bus(1'b1, HIA_IDX_CTL, {24'h0, 3'h4, ~b});
      bus(1'b0, HIA_IDX_STS, 0);
      chk(rd, {27'h0, b});
      bus(1'b1, HIA_IDX_CTL, {27'h0, b});
      bus(1'b0, HIA_IDX_STS, 0);
      chk(rd, {24'h0, 3'h4, b});
      chk({31'h0, host_int}, 32'h0);
      bus(1'b1, HIA_IDX_CTL, {24'h0, 3'h4, b});
      bus(1'b0, HIA_IDX_CTL, 0);
      chk(rd, {24'h0, 3'h4, b});
      chk({31'h0, host_int}, 32'h1);
      pulse(5'h00, i != 4, ~b[3:0]);
      bus(1'b0, HIA_IDX_STS, 0);
      chk(rd, {24'h0, 3'h4, b});
      pulse(5'h00, i == 4, b[3:0]);
      bus(1'b0, HIA_IDX_STS, 0);
      chk(rd, 32'h0);
      chk({31'h0, host_int}, 32'h0);
    end
  endtask
  // Event and clear in one cycle: the event wins
  task automatic t_set_wins;
    pulse(5'h01, 1'b0, 4'h1);
    bus(1'b0, HIA_IDX_STS, 0);
    chk(rd, 32'h01);
    pulse(5'h00, 1'b0, 4'h1);
    chk({16'h0, int_count}, 32'h5);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_irq();
    t_sources();
    t_set_wins();
    print_verdict();
  end
endmodule
